/* core/ssu_pkg.sv */
// Shared types and constants for the shift, store and subtract unit.
// Assumes 32-bit instruction words with the halfword form in bits 31:16.
package ssu_pkg;

	// Architected register width and count
	localparam int GPR_W = 64;
	localparam int WORD_W = 32;
	localparam logic [4:0] LAST_GPR = 5'h1F;

	// Instruction word bit that tells the long form from the short one
	localparam int LEN_BIT = 28;

	// Short encodings, all with the length bit clear
	localparam logic [7:0] OP_SHR_REG = 8'h40;
	localparam logic [7:0] OP_SRA_REG = 8'h41;
	localparam logic [7:0] OP_SUB = 8'h06;
	localparam logic [7:0] OP_SUBF = 8'h07;
	localparam logic [5:0] OP_SHR_IMM = 6'h1A;
	localparam logic [5:0] OP_SUBI = 6'h0A;
	localparam logic [3:0] OP_STB16 = 4'h8;
	localparam logic [3:0] OP_STH16 = 4'hA;
	localparam logic [3:0] OP_STW16 = 4'hC;

	// Long encodings, all with the length bit set
	localparam logic [5:0] OP_STB = 6'h15; // Bit 28 of the word must read as the length bit
	localparam logic [5:0] OP_STH = 6'h1D;
	localparam logic [5:0] OP_STW = 6'h17;
	localparam logic [5:0] OP_SRWI = 6'h1F;
	localparam logic [5:0] OP_EXT = 6'h06;
	localparam logic [9:0] XO_SRWI = 10'h238;
	localparam logic [3:0] XO_SUBFIC = 4'hB;
	localparam logic [3:0] XO_XORI = 4'hE;
	localparam logic [7:0] XO_STBU = 8'h04;
	localparam logic [7:0] XO_STHU = 8'h05;
	localparam logic [7:0] XO_STWU = 8'h06;
	localparam logic [7:0] XO_STMW = 8'h09;

	// Fetch steps and store-multiple stride
	localparam logic [31:0] STEP_SHORT = 32'h2;
	localparam logic [31:0] STEP_LONG = 32'h4;
	localparam logic [31:0] STEP_WORD = 32'h4;

	// Store sizes on the memory port
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_HALF = 2'h1;
	localparam logic [1:0] SZ_WORD = 2'h2;

	// Register port map
	localparam logic [5:0] A_GPR_LAST = 6'h1F;
	localparam logic [5:0] A_FLAGS = 6'h20;
	localparam logic [5:0] A_STATUS = 6'h21;

	// Instruction field views
	typedef struct packed {logic [7:0] op; logic [3:0] ry; logic [3:0] rx; logic [15:0] pad;} ssu_rr_s;
	typedef struct packed {logic [5:0] op; logic b6; logic [4:0] ui5; logic [3:0] rx; logic [15:0] pad;} ssu_im5_s;
	typedef struct packed {logic [3:0] op; logic [3:0] sd4; logic [3:0] rz; logic [3:0] rx; logic [15:0] pad;} ssu_sd4_s;
	typedef struct packed {logic [5:0] op; logic [4:0] rs; logic [4:0] ra; logic [15:0] d;} ssu_d_s;
	typedef struct packed {logic [5:0] op; logic [4:0] rs; logic [4:0] ra; logic [7:0] xo; logic [7:0] d8;} ssu_d8_s;
	typedef struct packed {
		logic [5:0] op; logic [4:0] rs; logic [4:0] ra; logic [3:0] xo;
		logic rc; logic f; logic [1:0] scl; logic [7:0] ui8;
	} ssu_scaled_imm8_s;
	typedef struct packed {logic [5:0] op; logic [4:0] rs; logic [4:0] ra; logic [4:0] sh; logic [9:0] xo; logic rc;} ssu_x_s;

	// Store request toward data memory
	typedef struct packed {logic we; logic [1:0] size; logic [31:0] addr; logic [31:0] data;} ssu_mem_req_s;

	// Software view of the flags and status words
	typedef struct packed {logic [23:0] rsvd; logic [3:0] cr0; logic [1:0] rsvd2; logic so; logic ca;} ssu_flags_s;
	typedef struct packed {logic [28:0] rsvd; logic busy; logic align; logic invalid;} ssu_status_s;

	// Sequencer states, Gray along idle to multiple and back
	typedef enum logic [0:0] {SSU_IDLE = 1'h0, SSU_MULTI = 1'h1} ssu_state_e;

endpackage

/* core/ssu_core.sv */
// Execution unit for compact-encoded shifts, stores, subtracts and XOR.
// Assumes one issue per cycle when ready, stores never stall, inputs synchronous to mclk.
//
// Behaviour
// - Zero arithmetic shift: sign-extend source, clear carry
// - Register arith shift 32-63: all sign, carry=sign
// - Shift count from SH, register low six, immediate
// - Logical right shift of low word, zero fill
// - Logical shift count 32-63 gives zero
// - Record form writes condition field from result
// - Long store address: base or zero plus displacement
// - Byte store low byte, short offset unscaled
// - Half store low half, short offset times two
// - Word store low word, short offset times four
// - Update writes address to base; base zero invalid
// - Store multiple: source through 31, step four
// - Misaligned store multiple raises alignment fault
// - Subtract: first plus not second plus one
// - Subtract from: not first plus second plus one
// - Immediate subtract-from sets carry from low word
// - Subtract immediate uses field plus one
// - XOR with expanded scaled immediate
// - Incoming instruction address low bit ignored
// - Generated fetch address has low bit zero
// - Wrong fixed field means invalid form
// - Arithmetic shift fills with sign bit
// - Carry only if negative and ones lost
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ps

module ssu_core (
	input wire logic mclk,
	input wire logic rst,
	input wire logic iss_valid,
	input wire logic [31:0] iss_word,
	input wire logic [31:0] iss_addr,
	output logic iss_ready_r,
	output logic [31:0] next_pc_r,
	output ssu_pkg::ssu_mem_req_s mem_req_r,
	output logic inv_form_r,
	output logic align_fault_r,
	input wire logic [5:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata_r
);

	// Short register field to register number: 0-7 stay, 8-15 become 24-31
	function automatic logic [4:0] map_r(input logic [3:0] r);
		return {r[3], r[3], r[2:0]};
	endfunction

	// Widen a word with zeros
	function automatic logic [ssu_pkg::GPR_W-1:0] zx(input logic [31:0] v);
		return ssu_pkg::GPR_W'(v);
	endfunction

	// Widen a word with its sign
	function automatic logic [ssu_pkg::GPR_W-1:0] sx(input logic [31:0] v);
		return ssu_pkg::GPR_W'(signed'(v));
	endfunction

	// Right shift of a word; returns {carry, result}
	function automatic logic [32:0] shr(input logic [31:0] v, input logic [5:0] n, input logic arith);
		logic [31:0] lost;
		logic sgn;
		lost = '0;
		sgn = arith & v[31];
		if (n[5]) begin
			return {sgn, {32{sgn}}};
		end
		lost = v & ~({32{1'h1}} << n[4:0]);
		return {sgn & (|lost), 32'(signed'({sgn, v}) >>> n[4:0])};
	endfunction

	// Condition field from a signed word result and summary overflow
	function automatic logic [3:0] cr_of(input logic [31:0] r, input logic so);
		logic lt;
		logic eq;
		lt = r[31];
		eq = (r == '0);
		return {lt, ~lt & ~eq, eq, so};
	endfunction

	// Scaled immediate: one byte placed by scale, the rest filled
	function automatic logic [ssu_pkg::GPR_W-1:0] scaled_imm8(input logic f, input logic [1:0] scl, input logic [7:0] ui);
		logic [31:0] w;
		w = {32{f}};
		w[{scl, 3'h0} +: 8] = ui;
		return {{32{f}}, w};
	endfunction

	// Store data cut to the access size
	function automatic logic [31:0] fit(input logic [1:0] sz, input logic [31:0] v);
		case (sz)
			ssu_pkg::SZ_BYTE: return 32'(v[7:0]);
			ssu_pkg::SZ_HALF: return 32'(v[15:0]);
			default: return v;
		endcase
	endfunction

	// Register file, flags and sequencer state
	logic [ssu_pkg::GPR_W-1:0] gpr [32];
	logic ca_r; // Carry flag
	logic so_r; // Summary overflow, software owned
	logic [3:0] cr0_r; // Condition field zero
	logic invalid_r; // Sticky invalid-form flag
	logic align_r; // Sticky alignment flag
	ssu_pkg::ssu_state_e state_r;
	ssu_pkg::ssu_state_e state_nxt;
	logic [4:0] mr_idx_r; // Next register of a store multiple
	logic [31:0] mr_ea_r; // Next address of a store multiple

	// Field views of the issued word
	ssu_pkg::ssu_rr_s w_rr;
	ssu_pkg::ssu_im5_s w_i5;
	ssu_pkg::ssu_sd4_s w_s4;
	ssu_pkg::ssu_d_s w_d;
	ssu_pkg::ssu_d8_s w_d8;
	ssu_pkg::ssu_scaled_imm8_s w_sc;
	ssu_pkg::ssu_x_s w_x;
	assign w_rr = iss_word;
	assign w_i5 = iss_word;
	assign w_s4 = iss_word;
	assign w_d = iss_word;
	assign w_d8 = iss_word;
	assign w_sc = iss_word;
	assign w_x = iss_word;

	// Decode results
	logic fire; // Instruction accepted this cycle
	logic is32; // Long form
	logic gw_en; // Register write
	logic [4:0] gw_idx;
	logic [ssu_pkg::GPR_W-1:0] gw_val;
	logic ca_en; // Carry write
	logic ca_val;
	logic rec_en; // Condition field write
	logic [31:0] rec_res;
	logic st_en; // Single store
	logic [1:0] st_size;
	logic [31:0] st_addr;
	logic [31:0] st_src;
	logic multi_go; // Start a store multiple
	logic bad; // Invalid form
	logic mis; // Misaligned store multiple
	logic [32:0] sr; // Shifter output
	logic [32:0] sum; // Carrying adder output
	logic [31:0] base; // Long-form base or zero
	logic [ssu_pkg::GPR_W-1:0] diff; // Short subtract result
	ssu_pkg::ssu_flags_s wflags; // Software write seen as flags
	assign wflags = reg_wdata;

	assign fire = iss_valid & iss_ready_r;
	assign is32 = iss_word[ssu_pkg::LEN_BIT];

	// Base is zero when the base field is zero
	assign base = (w_d.ra == '0) ? '0 : gpr[w_d.ra][31:0];

	// Instruction decode and datapath
	always_comb begin
		gw_en = 1'h0;
		gw_idx = '0;
		gw_val = '0;
		ca_en = 1'h0;
		ca_val = 1'h0;
		rec_en = 1'h0;
		rec_res = '0;
		st_en = 1'h0;
		st_size = ssu_pkg::SZ_WORD;
		st_addr = '0;
		st_src = '0;
		multi_go = 1'h0;
		bad = 1'h0;
		mis = 1'h0;
		sr = '0;
		sum = '0;
		diff = '0;
		if (is32) begin
			// Long forms
			case (w_d.op)
				ssu_pkg::OP_STB, ssu_pkg::OP_STH, ssu_pkg::OP_STW: begin
					st_en = 1'h1;
					st_addr = base + 32'(signed'(w_d.d));
					st_src = gpr[w_d.rs][31:0];
					if (w_d.op == ssu_pkg::OP_STB) begin
						st_size = ssu_pkg::SZ_BYTE;
					end else if (w_d.op == ssu_pkg::OP_STH) begin
						st_size = ssu_pkg::SZ_HALF;
					end
				end
				ssu_pkg::OP_SRWI: begin
					if (w_x.xo != ssu_pkg::XO_SRWI) begin
						bad = 1'h1;
					end else begin
						sr = shr(gpr[w_x.rs][31:0], 6'(w_x.sh), 1'h0);
						gw_en = 1'h1;
						gw_idx = w_x.ra;
						gw_val = zx(sr[31:0]);
						rec_en = w_x.rc;
						rec_res = sr[31:0];
					end
				end
				ssu_pkg::OP_EXT: begin
					case (w_sc.xo)
						ssu_pkg::XO_SUBFIC: begin
							// Not source plus immediate plus one, carry out of the low word
							sum = {1'h0, ~gpr[w_sc.ra][31:0]} + {1'h0, 32'(scaled_imm8(w_sc.f, w_sc.scl, w_sc.ui8))} + 33'h1;
							gw_en = 1'h1;
							gw_idx = w_sc.rs;
							gw_val = zx(sum[31:0]);
							ca_en = 1'h1;
							ca_val = sum[32];
							rec_en = w_sc.rc;
							rec_res = sum[31:0];
						end
						ssu_pkg::XO_XORI: begin
							gw_en = 1'h1;
							gw_idx = w_sc.ra;
							gw_val = gpr[w_sc.rs] ^ scaled_imm8(w_sc.f, w_sc.scl, w_sc.ui8);
							rec_en = w_sc.rc;
							rec_res = gw_val[31:0];
						end
						default: begin
							st_addr = base + 32'(signed'(w_d8.d8));
							st_src = gpr[w_d8.rs][31:0];
							case (w_d8.xo)
								ssu_pkg::XO_STBU, ssu_pkg::XO_STHU, ssu_pkg::XO_STWU: begin
									if (w_d8.ra == '0) begin
										bad = 1'h1;
									end else begin
										st_en = 1'h1;
										gw_en = 1'h1;
										gw_idx = w_d8.ra;
										gw_val = zx(st_addr);
										if (w_d8.xo == ssu_pkg::XO_STBU) begin
											st_size = ssu_pkg::SZ_BYTE;
										end else if (w_d8.xo == ssu_pkg::XO_STHU) begin
											st_size = ssu_pkg::SZ_HALF;
										end
									end
								end
								ssu_pkg::XO_STMW: begin
									// Misaligned start stores nothing and faults
									mis = (st_addr[1:0] != '0);
									multi_go = ~mis;
								end
								default: bad = 1'h1;
							endcase
						end
					endcase
				end
				default: bad = 1'h1;
			endcase
		end else if (w_s4.op == ssu_pkg::OP_STB16 || w_s4.op == ssu_pkg::OP_STH16 || w_s4.op == ssu_pkg::OP_STW16) begin
			// Short stores: offset scaled by access size
			st_en = 1'h1;
			st_src = gpr[map_r(w_s4.rz)][31:0];
			if (w_s4.op == ssu_pkg::OP_STB16) begin
				st_size = ssu_pkg::SZ_BYTE;
				st_addr = gpr[map_r(w_s4.rx)][31:0] + 32'(w_s4.sd4);
			end else if (w_s4.op == ssu_pkg::OP_STH16) begin
				st_size = ssu_pkg::SZ_HALF;
				st_addr = gpr[map_r(w_s4.rx)][31:0] + 32'({w_s4.sd4, 1'h0});
			end else begin
				st_addr = gpr[map_r(w_s4.rx)][31:0] + 32'({w_s4.sd4, 2'h0});
			end
		end else if (w_i5.op == ssu_pkg::OP_SHR_IMM) begin
			// Immediate shifts; bit six picks arithmetic
			sr = shr(gpr[map_r(w_i5.rx)][31:0], 6'(w_i5.ui5), w_i5.b6);
			gw_en = 1'h1;
			gw_idx = map_r(w_i5.rx);
			gw_val = w_i5.b6 ? sx(sr[31:0]) : zx(sr[31:0]);
			ca_en = w_i5.b6;
			ca_val = sr[32];
		end else if (w_i5.op == ssu_pkg::OP_SUBI) begin
			// Encodings 0..31 subtract 1..32
			diff = gpr[map_r(w_i5.rx)] + ~ssu_pkg::GPR_W'(w_i5.ui5) + ssu_pkg::GPR_W'(1'h0);
			gw_en = 1'h1;
			gw_idx = map_r(w_i5.rx);
			gw_val = diff;
			rec_en = w_i5.b6;
			rec_res = diff[31:0];
		end else begin
			// Register-register forms
			gw_idx = map_r(w_rr.rx);
			case (w_rr.op)
				ssu_pkg::OP_SHR_REG, ssu_pkg::OP_SRA_REG: begin
					sr = shr(gpr[gw_idx][31:0], gpr[map_r(w_rr.ry)][5:0], w_rr.op[0]);
					gw_en = 1'h1;
					gw_val = w_rr.op[0] ? sx(sr[31:0]) : zx(sr[31:0]);
					ca_en = w_rr.op[0];
					ca_val = sr[32];
				end
				ssu_pkg::OP_SUB: begin
					gw_en = 1'h1;
					gw_val = gpr[gw_idx] + ~gpr[map_r(w_rr.ry)] + ssu_pkg::GPR_W'(1'h1);
				end
				ssu_pkg::OP_SUBF: begin
					gw_en = 1'h1;
					gw_val = ~gpr[gw_idx] + gpr[map_r(w_rr.ry)] + ssu_pkg::GPR_W'(1'h1);
				end
				default: bad = 1'h1;
			endcase
		end
	end

	// Store multiple ends after register 31
	always_comb begin
		case (state_r)
			ssu_pkg::SSU_IDLE: state_nxt = (fire & multi_go) ? ssu_pkg::SSU_MULTI : ssu_pkg::SSU_IDLE;
			ssu_pkg::SSU_MULTI: state_nxt = (mr_idx_r == ssu_pkg::LAST_GPR) ? ssu_pkg::SSU_IDLE : ssu_pkg::SSU_MULTI;
			default: state_nxt = ssu_pkg::SSU_IDLE;
		endcase
	end

	// Sequencer state and walking register/address
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_r <= ssu_pkg::SSU_IDLE;
			mr_idx_r <= '0;
			mr_ea_r <= '0;
		end else begin
			state_r <= state_nxt;
			if (fire & multi_go) begin
				mr_idx_r <= w_d8.rs;
				mr_ea_r <= st_addr;
			end else if (state_r == ssu_pkg::SSU_MULTI) begin
				mr_idx_r <= mr_idx_r + 5'h1;
				mr_ea_r <= mr_ea_r + ssu_pkg::STEP_WORD;
			end
		end
	end

	// Ready only while no store multiple is walking
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			iss_ready_r <= 1'h0;
		end else begin
			iss_ready_r <= (state_nxt == ssu_pkg::SSU_IDLE);
		end
	end

	// Store requests; a walk step and an issue never coincide
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mem_req_r <= '0;
		end else if (state_r == ssu_pkg::SSU_MULTI) begin
			mem_req_r <= {1'h1, ssu_pkg::SZ_WORD, mr_ea_r, gpr[mr_idx_r][31:0]};
		end else if (fire & st_en) begin
			mem_req_r <= {1'h1, st_size, st_addr, fit(st_size, st_src)};
		end else begin
			mem_req_r <= '0;
		end
	end

	// Next fetch address from the issued one, low bit forced clear
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			next_pc_r <= '0;
		end else if (fire) begin
			next_pc_r <= {iss_addr[31:1], 1'h0} + (is32 ? ssu_pkg::STEP_LONG : ssu_pkg::STEP_SHORT);
		end
	end

	// Register file; issue write outranks software
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 32; i++) begin
				gpr[i] <= '0;
			end
		end else if (fire & gw_en & ~bad) begin
			gpr[gw_idx] <= gw_val;
		end else if (reg_wr & (reg_addr <= ssu_pkg::A_GPR_LAST)) begin
			gpr[reg_addr[4:0]] <= zx(reg_wdata);
		end
	end

	// Carry and condition field; hardware update outranks software
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ca_r <= 1'h0;
			so_r <= 1'h0;
			cr0_r <= '0;
		end else begin
			if (fire & ca_en) begin
				ca_r <= ca_val;
			end else if (reg_wr & (reg_addr == ssu_pkg::A_FLAGS)) begin
				ca_r <= reg_wdata[0];
			end
			if (fire & rec_en) begin
				cr0_r <= cr_of(rec_res, so_r);
			end else if (reg_wr & (reg_addr == ssu_pkg::A_FLAGS)) begin
				cr0_r <= wflags.cr0;
			end
			if (reg_wr & (reg_addr == ssu_pkg::A_FLAGS)) begin
				so_r <= reg_wdata[1];
			end
		end
	end

	// Sticky fault flags, write one to clear, a new fault wins
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			invalid_r <= 1'h0;
			align_r <= 1'h0;
			inv_form_r <= 1'h0;
			align_fault_r <= 1'h0;
		end else begin
			inv_form_r <= fire & bad;
			align_fault_r <= fire & mis;
			if (fire & bad) begin
				invalid_r <= 1'h1;
			end else if (reg_wr & (reg_addr == ssu_pkg::A_STATUS) & reg_wdata[0]) begin
				invalid_r <= 1'h0;
			end
			if (fire & mis) begin
				align_r <= 1'h1;
			end else if (reg_wr & (reg_addr == ssu_pkg::A_STATUS) & reg_wdata[1]) begin
				align_r <= 1'h0;
			end
		end
	end

	// Read data one cycle after the strobe, zero otherwise
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			reg_rdata_r <= '0;
		end else if (reg_rd) begin
			if (reg_addr <= ssu_pkg::A_GPR_LAST) begin
				reg_rdata_r <= gpr[reg_addr[4:0]][31:0];
			end else if (reg_addr == ssu_pkg::A_FLAGS) begin
				reg_rdata_r <= {24'h0, cr0_r, 2'h0, so_r, ca_r};
			end else if (reg_addr == ssu_pkg::A_STATUS) begin
				reg_rdata_r <= {29'h0, (state_r == ssu_pkg::SSU_MULTI), align_r, invalid_r};
			end else begin
				reg_rdata_r <= '0; // Unmapped
			end
		end else begin
			reg_rdata_r <= '0;
		end
	end

endmodule

/* verification/ssu_dmem_model.sv */
// Data memory port model that stands behind the unit's store requests.
// Assumes stores arrive as one-cycle pulses and are never stalled.
`timescale 1ns/1ps

module ssu_dmem_model (
	input wire logic mclk,
	input wire logic rst,
	input wire ssu_pkg::ssu_mem_req_s req,
	output int store_cnt
);
	// Count every accepted store; the port never refuses, so nothing is held back
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			store_cnt <= 0;
		end else if (req.we) begin
			store_cnt <= store_cnt + 1;
		end
	end
endmodule

/* verification/ssu_core_sva.sv */
// Port-level assertions for the shift, store and subtract unit.
// Assumes one clock domain; bound into every ssu_core instance.
`timescale 1ns/1ps

module ssu_core_sva (
	input wire logic mclk,
	input wire logic rst,
	input wire logic iss_valid,
	input wire logic [31:0] iss_word,
	input wire logic [31:0] iss_addr,
	input wire logic iss_ready_r,
	input wire logic [31:0] next_pc_r,
	input wire ssu_pkg::ssu_mem_req_s mem_req_r,
	input wire logic inv_form_r,
	input wire logic align_fault_r,
	input wire logic [5:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata_r
);
	default clocking dc @(posedge mclk);
	endclocking
	default disable iff (rst);
	wire logic take = iss_valid && iss_ready_r; // Issue accepted at this edge
	wire logic is_long = iss_word[28]; // Length bit of the offered word
	wire logic [31:0] pc_even = {iss_addr[31:1], 1'b0}; // Address with low bit ignored
	wire logic [31:0] req_addr = mem_req_r.addr; // Plain copy so $past sees a signal
	// Update store forms share the extended opcode
	wire logic upd = iss_word[31:26] == ssu_pkg::OP_EXT &&
		iss_word[15:8] inside {ssu_pkg::XO_STBU, ssu_pkg::XO_STHU, ssu_pkg::XO_STWU};

	a_pc_step: assert property (
		take |=> next_pc_r == $past(pc_even) + ($past(is_long) ? 32'h4 : 32'h2))
		else $error("fetch step wrong");
	a_byte_store: assert property (
		take && iss_word[31:28] == ssu_pkg::OP_STB16 |=> mem_req_r.we && mem_req_r.size == ssu_pkg::SZ_BYTE &&
		mem_req_r.data[31:8] == 24'h0)
		else $error("short byte store wrong");
	a_half_store: assert property (
		take && iss_word[31:28] == ssu_pkg::OP_STH16 |=> mem_req_r.we && mem_req_r.size == ssu_pkg::SZ_HALF &&
		mem_req_r.data[31:16] == 16'h0)
		else $error("short half store wrong");
	a_word_store: assert property (
		take && iss_word[31:28] == ssu_pkg::OP_STW16 |=> mem_req_r.we && mem_req_r.size == ssu_pkg::SZ_WORD)
		else $error("short word store wrong");
	a_upd_zero: assert property (
		take && upd && iss_word[20:16] == 5'h0 |=> inv_form_r && !mem_req_r.we)
		else $error("update with base zero accepted");
	a_multi_step: assert property (
		mem_req_r.we && !iss_ready_r |=> mem_req_r.we && mem_req_r.size == ssu_pkg::SZ_WORD &&
		req_addr == $past(req_addr) + 32'h4)
		else $error("store multiple step wrong");
	a_multi_bound: assert property (
		$fell(iss_ready_r) |-> ##[1:32] iss_ready_r)
		else $error("store multiple never ends");
	a_fault_quiet: assert property (
		align_fault_r |-> !mem_req_r.we && !inv_form_r && $past(take))
		else $error("alignment fault with store");
	a_inv_quiet: assert property (
		inv_form_r |-> !mem_req_r.we && $past(take))
		else $error("invalid form stored");
endmodule

bind ssu_core ssu_core_sva u_ssu_core_sva (.mclk(mclk), .rst(rst), .iss_valid(iss_valid), .iss_word(iss_word),
	.iss_addr(iss_addr), .iss_ready_r(iss_ready_r), .next_pc_r(next_pc_r), .mem_req_r(mem_req_r),
	.inv_form_r(inv_form_r), .align_fault_r(align_fault_r), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r));

/* verification/test_compact_isa_shift_store_sub_unit.sv */
// Random and corner-case bench for the shift, store and subtract unit.
// Assumes the memory model and the bound checker are compiled before it.
`timescale 1ns/1ps

module test_compact_isa_shift_store_sub_unit;
	logic mclk = 1'b0; // 20 MHz core clock
	logic rst = 1'b1; // Held six cycles at start
	logic iss_valid = 1'b0;
	logic [31:0] iss_word = 32'h0;
	logic [31:0] iss_addr = 32'h0;
	logic [5:0] reg_addr = 6'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic iss_ready_r;
	logic [31:0] next_pc_r;
	ssu_pkg::ssu_mem_req_s mem_req_r;
	logic inv_form_r;
	logic align_fault_r;
	logic [31:0] reg_rdata_r;
	int store_cnt; // Stores seen by the model
	int failures = 0;
	int num_checks = 0;
	int seed = 32'hE76A; // Fixed so runs repeat
	int cnt[6] = '{0, 1, 31, 32, 33, 63}; // Shift count corners
	logic [3:0] sop[3] = '{ssu_pkg::OP_STB16, ssu_pkg::OP_STH16, ssu_pkg::OP_STW16};
	logic [5:0] lop[3] = '{ssu_pkg::OP_STB, ssu_pkg::OP_STH, ssu_pkg::OP_STW};
	logic [31:0] a, b, x, ea;
	logic [32:0] e; // Carry above the result
	int n, m, s;

	always #25 mclk = ~mclk;

	ssu_core u_ssu_core (.mclk(mclk), .rst(rst), .iss_valid(iss_valid), .iss_word(iss_word), .iss_addr(iss_addr),
		.iss_ready_r(iss_ready_r), .next_pc_r(next_pc_r), .mem_req_r(mem_req_r), .inv_form_r(inv_form_r),
		.align_fault_r(align_fault_r), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r));
	ssu_dmem_model u_ssu_dmem_model (.mclk(mclk), .rst(rst), .req(mem_req_r), .store_cnt(store_cnt));

	// Compare wide enough for a whole store request
	task automatic chk(input logic [66:0] got, input logic [66:0] exp, input string msg);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic wr(input logic [5:0] ad, input logic [31:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= ad;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
		#1;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [5:0] ad, input logic [31:0] exp, input string msg);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= ad;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata_r, exp, msg);
	endtask

	// Offer one word from a random address; leaves us in the cycle where pulses stand
	task automatic issue(input logic [31:0] w);
		logic [31:0] pc;
		pc = $random(seed);
		while (iss_ready_r !== 1'b1) begin
			@(posedge mclk);
			#1;
		end
		@(posedge mclk);
		iss_valid <= 1'b1;
		iss_word <= w;
		iss_addr <= pc;
		@(posedge mclk);
		iss_valid <= 1'b0;
		#1;
		chk(next_pc_r, {pc[31:1], 1'b0} + (w[28] ? 32'h4 : 32'h2), "next pc");
	endtask

	function automatic logic [32:0] sra_exp(input logic [31:0] v, input int k);
		if (k == 0) begin
			return {1'b0, v};
		end
		if (k > 31) begin
			return {v[31], {32{v[31]}}};
		end
		return {v[31] && ((v & ((32'h1 << k) - 32'h1)) != 32'h0), 32'($signed(v) >>> k)};
	endfunction

	// Low word of the scaled immediate: byte placed by scale, rest filled
	function automatic logic [31:0] scaled_imm8(input logic f, input logic [1:0] scl, input logic [7:0] u);
		return ({32{f}} & ~(32'hFF << (8 * scl))) | (32'(u) << (8 * scl));
	endfunction

	// Condition field with summary overflow held set by software
	function automatic logic [3:0] cr(input logic [31:0] r);
		return {r[31], !r[31] && r != 32'h0, r == 32'h0, 1'b1};
	endfunction

	function automatic logic [31:0] msk(input int k);
		return (k == 2) ? 32'hFFFF_FFFF : ((32'h1 << (8 << k)) - 32'h1);
	endfunction

	task automatic end_of_test;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Hang guard, far beyond the thousand or so cycles the run needs
	initial begin
		#2000000;
		failures++;
		$display("[ERR] %0t watchdog expired", $time);
		end_of_test();
	end

	initial begin
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		// Four shift kinds over corner and random counts
		for (int i = 0; i < 16; i++) begin
			a = $random(seed);
			x = $random(seed);
			n = (i < 6) ? cnt[i] : x[5:0];
			wr(6'h02, {x[31:6], 6'(n)});
			for (int k = 0; k < 4; k++) begin
				m = (k > 1) ? (n % 32) : n;
				e = k[0] ? sra_exp(a, m) : {1'b0, (m > 31) ? 32'h0 : (a >> m)};
				wr(6'h01, a);
				issue((k > 1) ? {6'h1A, k[0], 5'(n), 4'h1, 16'h0} : {7'h20, k[0], 8'h21, 16'h0});
				rd(6'h01, e[31:0], "shift");
				if (k[0]) begin
					rd(6'h20, {31'h0, e[32]}, "shift carry");
				end
			end
		end
		// Record form sets the condition field, the last pass leaves it alone
		wr(6'h20, 32'h2);
		for (int i = 0; i < 4; i++) begin
			a = (i == 2) ? 32'h1 : 32'h8000_0001;
			e = {1'b0, a >> (i % 3)};
			wr(6'h01, a);
			issue({6'h1F, 5'h01, 5'h04, 5'(i % 3), ssu_pkg::XO_SRWI, 1'(i < 3)});
			rd(6'h04, e[31:0], "long shift");
			rd(6'h20, {24'h0, cr((i < 3) ? e[31:0] : 32'h0), 4'h2}, "record");
		end
		issue({6'h1F, 5'h01, 5'h04, 5'h0, 10'h239, 1'b0});
		chk(inv_form_r, 1'b1, "fixed field");
		rd(6'h21, 32'h1, "invalid sticky");
		wr(6'h21, 32'h1);
		// Subtract family and XOR with random operands
		for (int i = 0; i < 10; i++) begin
			a = $random(seed);
			b = $random(seed);
			x = $random(seed);
			wr(6'h1A, b);
			wr(6'h01, a);
			issue({ssu_pkg::OP_SUB, 8'hA1, 16'h0});
			rd(6'h01, a - b, "sub");
			wr(6'h01, a);
			issue({ssu_pkg::OP_SUBF, 8'hA1, 16'h0});
			rd(6'h01, b - a, "subf");
			wr(6'h01, a);
			issue({ssu_pkg::OP_SUBI, 1'b0, x[4:0], 4'h1, 16'h0});
			rd(6'h01, a - 32'(x[4:0]) - 32'h1, "subi");
			wr(6'h01, a);
			e = {1'b0, ~a} + {1'b0, scaled_imm8(x[5], x[7:6], x[15:8])} + 33'h1;
			issue({6'h06, 5'h05, 5'h01, 4'hB, 1'b0, x[5], x[7:6], x[15:8]});
			rd(6'h05, e[31:0], "subfic");
			rd(6'h20, {24'h0, 4'h3, 3'h1, e[32]}, "subfic carry");
			issue({6'h06, 5'h01, 5'h06, 4'hE, 1'b0, x[5], x[7:6], x[15:8]});
			rd(6'h06, a ^ scaled_imm8(x[5], x[7:6], x[15:8]), "xori");
		end
		wr(6'h01, 32'h5);
		issue({ssu_pkg::OP_SUBI, 1'b1, 5'h1F, 4'h1, 16'h0});
		rd(6'h20, {24'h0, 4'h9, 3'h1, e[32]}, "subi record");
		// Stores of every size: short, long with and without base, update forms
		for (int i = 0; i < 9; i++) begin
			a = $random(seed);
			b = $random(seed);
			x = $random(seed);
			s = i % 3;
			wr(6'h19, a);
			wr(6'h03, b);
			wr(6'h04, a);
			issue({sop[s], x[3:0], 8'h39, 16'h0});
			chk(mem_req_r, {1'b1, 2'(s), a + (32'(x[3:0]) << s), b & msk(s)}, "short store");
			issue({lop[s], 5'h03, (i < 3) ? 5'h00 : 5'h04, x[31:16]});
			ea = ((i < 3) ? 32'h0 : a) + {{16{x[31]}}, x[31:16]};
			chk(mem_req_r, {1'b1, 2'(s), ea, b & msk(s)}, "long store");
			ea = a + {{24{x[15]}}, x[15:8]};
			issue({6'h06, 5'h03, 5'h04, 8'h04 + 8'(s), x[15:8]});
			chk(mem_req_r, {1'b1, 2'(s), ea, b & msk(s)}, "update store");
			rd(6'h04, ea, "update base");
		end
		issue({6'h06, 5'h03, 5'h00, 8'h06, 8'h10});
		chk({inv_form_r, mem_req_r.we}, 2'h2, "update base zero");
		// Store multiple from register 29, then from a misaligned base
		for (int r = 29; r < 32; r++) begin
			wr(6'(r), 32'hA000_0000 + 32'(r));
		end
		wr(6'h04, 32'h1000);
		n = store_cnt;
		issue({6'h06, 5'h1D, 5'h04, ssu_pkg::XO_STMW, 8'hFC});
		@(posedge mclk); // First walk store comes one cycle after the issue pulse
		#1;
		for (int r = 29; r < 32; r++) begin
			chk(mem_req_r, {1'b1, ssu_pkg::SZ_WORD, 32'h0FFC + 32'(4 * (r - 29)), 32'hA000_0000 + 32'(r)}, "stmw");
			@(posedge mclk);
			#1;
		end
		chk(32'(store_cnt - n), 32'h3, "store count");
		wr(6'h04, 32'h1002);
		issue({6'h06, 5'h1D, 5'h04, ssu_pkg::XO_STMW, 8'h00});
		chk({align_fault_r, mem_req_r.we}, 2'h2, "misaligned");
		rd(6'h21, 32'h3, "status");
		wr(6'h21, 32'h3);
		rd(6'h21, 32'h0, "status clear");
		rd(6'h3F, 32'h0, "unmapped");
		end_of_test();
	end
endmodule
